//--- core/gct_bank.sv
// Purpose: Five gated 32-bit counter/timer channels behind an APB slave.
// Assumes: Pins are asynchronous; clk is 200 MHz.
// Notes:   An 18 MHz base is made by a fractional accumulator on clk.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "gct_params.svh"
// Behaviour
// - Five independent 32-bit channels with pins.
// - Sample list: lower word, optional upper.
// - Latch full count when lower sampled.
// - Internal clock from 18 MHz base.
// - Internal pacing sets pulse output frequency.
// - External clock up to 9 MHz accepted.
// - External clock advances on rising edges.
// - Divider 2 to 2^32 on base.
// - No gate: start command enables.
// - Low gate: run while gate low.
// - High gate: run while gate high.
// - Falling gate edge enables operation.
// - Rising gate edge enables operation.
// - High-to-low type: low part active.
// - Low-to-high type: high part active.
// - Duty percent sets active share.
// - Sampling paced by conversion clock or pin.
// - Event count: rising edges while gated.
module gct_bank (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Channel pins
    input  wire logic [`GCT_NCH-1:0] ctClkPin,
    input  wire logic [`GCT_NCH-1:0] ctGatePin,
    output logic      [`GCT_NCH-1:0] ctOut,
    // Conversion clock pin and sample stream
    input  wire logic                convClkPin,
    output logic      [15:0]         sampleData,
    output logic                     sampleValid,
    output logic                     sampleUpper
);
    import gct_pkg::*;

    // ------------------------------------------------------------------------
    // Registers and shared signals
    // ------------------------------------------------------------------------
    logic [5:0]  ctrl_ff  [`GCT_NCH];
    logic [31:0] div_ff   [`GCT_NCH];
    logic [6:0]  duty_ff  [`GCT_NCH];
    logic [31:0] cnt_ff   [`GCT_NCH];
    logic [31:0] phase_ff [`GCT_NCH];
    logic [`GCT_NCH-1:0] run_ff;
    logic [`GCT_NCH-1:0] armed_ff;
    logic [`GCT_NCH-1:0] out_ff;
    logic [`GCT_NCH-1:0] en;
    logic [`GCT_NCH-1:0] tick;
    logic [`GCT_NCH-1:0] clkLvl;
    logic [`GCT_NCH-1:0] clkRise;
    logic [`GCT_NCH-1:0] gateLvl;
    logic [`GCT_NCH-1:0] gateRise;
    logic [`GCT_NCH-1:0] gateFall;
    logic [`GCT_NCH-1:0] unusedClkFall;
    logic [`GCT_NCH*`GCT_CW-1:0] countFlat;
    logic [4:0]  list_ff;
    logic [31:0] conv_ff;
    logic [31:0] convCnt_ff;
    logic [8:0]  acc_ff;
    logic        baseTick;
    logic        convRise;
    logic        convTick;
    logic [31:0] rdNext;
    logic [31:0] prdata_ff;
    logic        wrEn;
    logic        isCh;
    logic        mapped;
    logic        unusedConvLvl;
    logic        unusedConvFall;
    logic [2:0]  chIdx;
    logic [1:0]  chReg;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    gct_sync #(.W(2*`GCT_NCH+1)) gct_sync_i (
        .clk   (clk),
        .rst   (rst),
        .pinIn ({convClkPin, ctGatePin, ctClkPin}),
        .level ({unusedConvLvl, gateLvl, clkLvl}),
        .rise  ({convRise, gateRise, clkRise}),
        .fall  ({unusedConvFall, gateFall, unusedClkFall})
    );

    // ------------------------------------------------------------------------
    // 18 MHz base: adds 18 per clk and wraps at 200, so ticks average 18 MHz.
    // ------------------------------------------------------------------------
    // Short periods jitter by one clk.
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_ff <= 9'h0;
        end else if (acc_ff + `GCT_BASE_MHZ >= `GCT_CLK_MHZ) begin
            acc_ff <= acc_ff + `GCT_BASE_MHZ - `GCT_CLK_MHZ;
        end else begin
            acc_ff <= acc_ff + `GCT_BASE_MHZ;
        end
    end
    assign baseTick = (acc_ff + `GCT_BASE_MHZ >= `GCT_CLK_MHZ);

    // ------------------------------------------------------------------------
    // APB decode: answers with no wait state, read data taken in the setup cycle.
    // ------------------------------------------------------------------------
    assign chIdx  = paddr[6:4];
    assign chReg  = paddr[3:2];
    assign isCh   = (paddr < `GCT_ADDR_START) && (paddr[1:0] == 2'h0);
    assign mapped = isCh || paddr == `GCT_ADDR_START || paddr == `GCT_ADDR_STOP
                 || paddr == `GCT_ADDR_LIST || paddr == `GCT_ADDR_CONV
                 || paddr == `GCT_ADDR_STAT;
    assign wrEn   = psel && penable && pwrite && mapped;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_ff;

    // Read mux for the addressed word.
    always_comb begin
        rdNext = 32'h0;
        if (isCh) begin
            unique case (chReg)
                `GCT_REG_CTRL: rdNext = {26'h0, ctrl_ff[chIdx]};
                `GCT_REG_DIV:  rdNext = div_ff[chIdx];
                `GCT_REG_DUTY: rdNext = {25'h0, duty_ff[chIdx]};
                `GCT_REG_CNT:  rdNext = cnt_ff[chIdx];
            endcase
        end else if (paddr == `GCT_ADDR_LIST) begin
            rdNext = {27'h0, list_ff};
        end else if (paddr == `GCT_ADDR_CONV) begin
            rdNext = conv_ff;
        end else if (paddr == `GCT_ADDR_STAT) begin
            rdNext = {17'h0, out_ff, en, run_ff};
        end
    end

    // Read data is registered in the setup cycle and stands through access.
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_ff <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= rdNext;
        end
    end

    // Configuration writes; out-of-range list indices are stored as 0 and out-of-range channels are ignored.
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < `GCT_NCH; i++) begin
                ctrl_ff[i] <= 6'h0;
                div_ff[i]  <= `GCT_DIV_RST;
                duty_ff[i] <= `GCT_DUTY_RST;
            end
            list_ff <= 5'h0;
            conv_ff <= `GCT_CONV_RST;
        end else if (wrEn) begin
            if (isCh && chIdx < `GCT_NCH) begin
                if (chReg == `GCT_REG_CTRL) begin
                    ctrl_ff[chIdx] <= pwdata[5:0];
                end
                if (chReg == `GCT_REG_DIV) begin
                    div_ff[chIdx] <= (pwdata == 32'h0) ? 32'h1 : pwdata;
                end
                if (chReg == `GCT_REG_DUTY) begin
                    duty_ff[chIdx] <= (pwdata > 32'd100) ? 7'd100 : pwdata[6:0];
                end
            end
            if (paddr == `GCT_ADDR_LIST) begin
                list_ff <= {pwdata[4:3], (pwdata[2:0] > 3'd4) ? 3'd0 : pwdata[2:0]};
            end
            if (paddr == `GCT_ADDR_CONV) begin
                conv_ff <= pwdata;
            end
        end
    end

    // Start sets and stop clears the run bits; start is decoded first, though one write addresses only one of them.
    always_ff @(posedge clk) begin
        if (rst) begin
            run_ff <= '0;
        end else if (wrEn && paddr == `GCT_ADDR_START) begin
            run_ff <= run_ff | pwdata[`GCT_NCH-1:0];
        end else if (wrEn && paddr == `GCT_ADDR_STOP) begin
            run_ff <= run_ff & ~pwdata[`GCT_NCH-1:0];
        end
    end

    // ------------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------------
    for (genvar c = 0; c < `GCT_NCH; c++) begin : g_ch
        gct_gate_e   gate;
        logic        ext, pol, rate, startWr, active;
        logic [39:0] prod;
        logic [31:0] actLen;

        assign gate    = gct_gate_e'(ctrl_ff[c][2:0]);
        assign ext     = ctrl_ff[c][`GCT_CTRL_EXT];
        assign pol     = ctrl_ff[c][`GCT_CTRL_POL];
        assign rate    = ctrl_ff[c][`GCT_CTRL_RATE];
        assign startWr = wrEn && paddr == `GCT_ADDR_START && pwdata[c];

        // A stored value of N divides by N+1; external mode counts pin edges.
        assign tick[c] = ext ? clkRise[c] : baseTick;

        // Edge gates arm once per start; a new start re-arms the wait.
        // A gate edge that meets a restart still arms.
        always_ff @(posedge clk) begin
            if (rst) begin
                armed_ff[c] <= 1'b0;
            end else if (run_ff[c] && gate == GCT_GATE_FALL && gateFall[c]) begin
                armed_ff[c] <= 1'b1;
            end else if (run_ff[c] && gate == GCT_GATE_RISE && gateRise[c]) begin
                armed_ff[c] <= 1'b1;
            end else if (startWr) begin
                armed_ff[c] <= 1'b0;
            end
        end

        // Gate qualification of the run bit.
        always_comb begin
            unique case (gate)
                GCT_GATE_NONE: en[c] = run_ff[c];
                GCT_GATE_LOW:  en[c] = run_ff[c] && !gateLvl[c];
                GCT_GATE_HIGH: en[c] = run_ff[c] && gateLvl[c];
                GCT_GATE_FALL: en[c] = run_ff[c] && armed_ff[c];
                GCT_GATE_RISE: en[c] = run_ff[c] && armed_ff[c];
                default:       en[c] = 1'b0;
            endcase
        end

        // Event count: one step per qualified tick, wrapping at 2^32.
        always_ff @(posedge clk) begin
            if (rst || startWr) begin
                cnt_ff[c] <= 32'h0;
            end else if (en[c] && tick[c]) begin
                cnt_ff[c] <= cnt_ff[c] + 32'h1;
            end
        end

        // Output period is div+1 ticks; the phase restarts whenever disabled.
        always_ff @(posedge clk) begin
            if (rst || !en[c] || !rate) begin
                phase_ff[c] <= 32'h0;
            end else if (tick[c]) begin
                phase_ff[c] <= (phase_ff[c] >= div_ff[c]) ? 32'h0
                             : phase_ff[c] + 32'h1;
            end
        end

        // Active ticks per period, rounded down; 40 bits keep the product exact.
        assign prod   = ({8'h0, div_ff[c]} + 40'h1) * {33'h0, duty_ff[c]};
        assign actLen = 32'(prod / `GCT_DUTY_FULL);
        assign active = rate && en[c] && (phase_ff[c] < actLen);

        // Active portion is low for high-to-low, high for low-to-high.
        // Reset drives the idle high level of polarity zero.
        always_ff @(posedge clk) begin
            if (rst) begin
                out_ff[c] <= 1'b1;
            end else begin
                out_ff[c] <= pol ? active : !active;
            end
        end

        assign countFlat[c*`GCT_CW +: `GCT_CW] = cnt_ff[c];

        low_gate_a: assert property (@(posedge clk) disable iff (rst)
            gate == GCT_GATE_LOW && en[c] |-> !gateLvl[c])
            else $error("low gate ran while gate high");
        high_gate_a: assert property (@(posedge clk) disable iff (rst)
            gate == GCT_GATE_HIGH && run_ff[c] && gateLvl[c] |-> en[c])
            else $error("high gate held off while gate high");
        edge_arm_a: assert property (@(posedge clk) disable iff (rst)
            run_ff[c] && gate == GCT_GATE_FALL && gateFall[c] && !startWr
            |=> armed_ff[c])
            else $error("falling gate edge did not arm");
        rise_arm_a: assert property (@(posedge clk) disable iff (rst)
            run_ff[c] && gate == GCT_GATE_RISE && gateRise[c] |=> armed_ff[c])
            else $error("rising gate edge did not arm");
        count_gate_a: assert property (@(posedge clk) disable iff (rst)
            !startWr && $past(!startWr) && cnt_ff[c] != $past(cnt_ff[c])
            |-> $past(en[c] && tick[c]))
            else $error("count moved without qualified tick");
        idle_level_a: assert property (@(posedge clk) disable iff (rst)
            !en[c] && !pol ##1 !pol |-> out_ff[c])
            else $error("idle output not at inactive level");
    end

    // ------------------------------------------------------------------------
    // Conversion pacing and sample stream
    // ------------------------------------------------------------------------
    // A pin edge replaces the internal wrap.
    always_ff @(posedge clk) begin
        if (rst || convCnt_ff >= conv_ff) begin
            convCnt_ff <= 32'h0;
        end else begin
            convCnt_ff <= convCnt_ff + 32'h1;
        end
    end
    assign convTick = list_ff[`GCT_LIST_EXTCONV] ? convRise
                    : (convCnt_ff >= conv_ff);

    gct_sampler gct_sampler_i (
        .clk         (clk),
        .rst         (rst),
        .convTick    (convTick),
        .chanSel     (list_ff[2:0]),
        .upperEn     (list_ff[`GCT_LIST_UPPER]),
        .countFlat   (countFlat),
        .sampleData  (sampleData),
        .sampleValid (sampleValid),
        .sampleUpper (sampleUpper)
    );

    assign ctOut = out_ff;

    sequence startCmd_s;
        wrEn && paddr == `GCT_ADDR_START && pwdata[0];
    endsequence
    start_run_a: assert property (@(posedge clk) disable iff (rst)
        startCmd_s |=> run_ff[0])
        else $error("start command did not set run");
    base_rate_a: assert property (@(posedge clk) disable iff (rst)
        baseTick |=> !baseTick)
        else $error("base ticks back to back");
    conv_pace_a: assert property (@(posedge clk) disable iff (rst)
        list_ff[`GCT_LIST_EXTCONV] && !convRise |-> !convTick)
        else $error("sample taken without conversion clock edge");
endmodule
`default_nettype wire

//--- core/gct_sampler.sv
// Purpose: Places one counter in the sample stream as a lower word and, with upperEn, an upper word.
// Assumes: convTick is a one-cycle pulse; chanSel is already in range.
// Notes:   The whole count is held when the lower word goes out.
`timescale 1ns/1ps
`default_nettype none
`include "gct_params.svh"
module gct_sampler (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // Pacing and list
    input  wire logic                          convTick,
    input  wire logic [2:0]                    chanSel,
    input  wire logic                          upperEn,
    // Live counts
    input  wire logic [`GCT_NCH*`GCT_CW-1:0]   countFlat,
    // Sample stream
    output logic      [15:0]                   sampleData,
    output logic                               sampleValid,
    output logic                               sampleUpper
);
    import gct_pkg::*;
    gct_samp_e   state_ff;
    logic [31:0] hold_ff;
    logic [15:0] data_ff;
    logic        valid_ff;
    logic        upper_ff;
    logic [31:0] live;

    assign live = countFlat[chanSel*`GCT_CW +: `GCT_CW];

    // A tick always restarts at the lower word so a fast clock cannot skew the pair.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= GCT_S_LOWER;
            hold_ff  <= 32'h0;
            data_ff  <= 16'h0;
            valid_ff <= 1'b0;
            upper_ff <= 1'b0;
        end else if (convTick) begin
            hold_ff  <= live;
            data_ff  <= live[15:0];
            valid_ff <= 1'b1;
            upper_ff <= 1'b0;
            state_ff <= upperEn ? GCT_S_UPPER : GCT_S_LOWER;
        end else if (state_ff == GCT_S_UPPER) begin
            data_ff  <= hold_ff[31:16];
            valid_ff <= 1'b1;
            upper_ff <= 1'b1;
            state_ff <= GCT_S_LOWER;
        end else begin
            valid_ff <= 1'b0;
            upper_ff <= 1'b0;
        end
    end

    assign sampleData  = data_ff;
    assign sampleValid = valid_ff;
    assign sampleUpper = upper_ff;

    sequence lowerOut_s;
        convTick && upperEn ##1 sampleValid && !sampleUpper && !convTick;
    endsequence
    upper_follows_a: assert property (@(posedge clk) disable iff (rst)
        lowerOut_s |=> sampleValid && sampleUpper)
        else $error("upper word did not follow the lower word");
    upper_coherent_a: assert property (@(posedge clk) disable iff (rst)
        convTick ##1 !convTick |=> sampleUpper |-> sampleData == $past(live[31:16], 2))
        else $error("upper word differs from latched count");
endmodule
`default_nettype wire

//--- core/gct_sync.sv
// Purpose: Two-flop synchroniser with edge detection for external pins.
// Assumes: Pins are asynchronous to clk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module gct_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Raw pins
    input  wire logic [W-1:0] pinIn,
    // Synchronised level and edges
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] prev_ff;

    // Three stages: the third only gives the edge detector a settled copy.
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
            prev_ff <= '0;
        end else begin
            meta_ff <= pinIn;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // Edges are taken between two settled samples only.
    assign level = sync_ff;
    assign rise  = sync_ff & ~prev_ff;
    assign fall  = ~sync_ff & prev_ff;
endmodule
`default_nettype wire

//--- pkg/gct_params.svh
// Purpose: Offsets, fields, reset values and timing counts of the counter bank.
// Assumes: Included by bare name from design and bench files.
// Notes:   Definitions only.
`ifndef GCT_PARAMS_SVH
`define GCT_PARAMS_SVH
// ----------------------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------------------
`define GCT_NCH          5
`define GCT_CW           32
`define GCT_CLK_MHZ      9'd200
`define GCT_BASE_MHZ     9'd18
`define GCT_EXT_MIN_MHZ  "0.0000000042"
`define GCT_EXT_MAX_KHZ  9000
`define GCT_DUTY_FULL    40'd100
// ----------------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------------
`define GCT_CH_STRIDE    8'h10
`define GCT_REG_CTRL     2'h0
`define GCT_REG_DIV      2'h1
`define GCT_REG_DUTY     2'h2
`define GCT_REG_CNT      2'h3
`define GCT_ADDR_START   8'h50
`define GCT_ADDR_STOP    8'h54
`define GCT_ADDR_LIST    8'h58
`define GCT_ADDR_CONV    8'h5c
`define GCT_ADDR_STAT    8'h60
// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define GCT_CTRL_EXT     3
`define GCT_CTRL_POL     4
`define GCT_CTRL_RATE    5
`define GCT_LIST_UPPER   3
`define GCT_LIST_EXTCONV 4
`define GCT_DIV_RST      32'h0000_0001
`define GCT_DUTY_RST     7'h32
`define GCT_CONV_RST     32'h0000_00c7
`endif

//--- pkg/gct_pkg.sv
// Purpose: Types shared by the counter bank files.
// Assumes: Constants come from gct_params.svh.
// Notes:   Gate encoding matches the low three bits of the control register.
package gct_pkg;
    typedef enum logic [2:0] {
        GCT_GATE_NONE = 3'h0,
        GCT_GATE_LOW  = 3'h1,
        GCT_GATE_HIGH = 3'h2,
        GCT_GATE_FALL = 3'h3,
        GCT_GATE_RISE = 3'h4
    } gct_gate_e;
    typedef enum logic {
        GCT_S_LOWER = 1'b0,
        GCT_S_UPPER = 1'b1
    } gct_samp_e;
endpackage

//--- tb/gct_bank_tb.sv
// Purpose: Self-checking bench for the counter bank.
// Assumes: Zero-wait APB slave; pins come from gct_pins_model.
// Notes:   Rate checks allow one period of edge count and 20 clocks of active time.
`timescale 1ns/1ps
`default_nettype none
`include "gct_params.svh"
module gct_bank_tb;
    import gct_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, sampleValid, sampleUpper, convClkPin;
    logic [4:0]  ctClkPin, ctGatePin, ctOut;
    logic [15:0] sampleData;
    int          failures = 0, num_checks = 0;
    always #2.5 clk = ~clk;
    gct_bank gct_bank_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ctClkPin(ctClkPin),
        .ctGatePin(ctGatePin), .ctOut(ctOut), .convClkPin(convClkPin),
        .sampleData(sampleData), .sampleValid(sampleValid),
        .sampleUpper(sampleUpper));
    gct_pins_model gct_pins_model_i (.clk(clk), .ctClkPin(ctClkPin),
        .ctGatePin(ctGatePin), .convClkPin(convClkPin), .ctOut(ctOut));
    // ----
    // Shared tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Read data and the error flag are taken at the edge that sees pready.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            failures++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [7:0] ra(input int ch, input logic [1:0] r);
        return 8'(ch * 16 + r * 4);
    endfunction
    task automatic waitValid(input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            if (sampleValid === 1'b1) break;
        end
        if (i == n) begin
            failures++;
            end_sim();
        end
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        apb(0, ra(0, `GCT_REG_DIV), 0); check(rd, `GCT_DIV_RST);
        apb(0, ra(4, `GCT_REG_DUTY), 0); check(rd, 32'(`GCT_DUTY_RST));
        apb(0, `GCT_ADDR_CONV, 0); check(rd, `GCT_CONV_RST);
        check(32'(ctOut), 32'h1f);
        apb(0, 8'h7c, 0); check(32'(err), 32'h1); check(rd, 32'h0);
        apb(1, ra(2, `GCT_REG_DIV), 0); apb(0, ra(2, `GCT_REG_DIV), 0);
        check(rd, 32'h1);
        apb(1, ra(2, `GCT_REG_DUTY), 32'hff); apb(0, ra(2, `GCT_REG_DUTY), 0);
        check(rd, 32'h64);
        $display("test reset done");
    endtask
    // Count only runs after the start command.
    task automatic t_none();
        apb(1, ra(0, `GCT_REG_CTRL), 32'h1 << `GCT_CTRL_EXT);
        gct_pins_model_i.clkPulses(0, 2);
        apb(0, ra(0, `GCT_REG_CNT), 0); check(rd, 32'h0);
        apb(1, `GCT_ADDR_START, 32'h1);
        gct_pins_model_i.clkPulses(0, 3);
        apb(0, ra(0, `GCT_REG_CNT), 0); check(rd, 32'h3);
        apb(1, `GCT_ADDR_STOP, 32'h1);
        gct_pins_model_i.clkPulses(0, 2);
        apb(0, ra(0, `GCT_REG_CNT), 0); check(rd, 32'h3);
        $display("test no gate done");
    endtask
    // Level gates stop again when the gate falls back; edge gates stay armed.
    task automatic t_gates();
        int        chs[4] = '{1, 2, 3, 4};
        gct_gate_e gts[4] = '{GCT_GATE_HIGH, GCT_GATE_LOW, GCT_GATE_RISE, GCT_GATE_FALL};
        logic      idle[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++) begin
            gct_pins_model_i.setGate(chs[i], idle[i]);
            apb(1, ra(chs[i], `GCT_REG_CTRL), 32'(gts[i]) | (32'h1 << `GCT_CTRL_EXT));
            apb(1, `GCT_ADDR_START, 32'h1 << chs[i]);
            gct_pins_model_i.clkPulses(chs[i], 3);
            apb(0, ra(chs[i], `GCT_REG_CNT), 0); check(rd, 32'h0);
            gct_pins_model_i.setGate(chs[i], ~idle[i]);
            gct_pins_model_i.clkPulses(chs[i], 5);
            apb(0, ra(chs[i], `GCT_REG_CNT), 0); check(rd, 32'h5);
            gct_pins_model_i.setGate(chs[i], idle[i]);
            gct_pins_model_i.clkPulses(chs[i], 2);
            apb(0, ra(chs[i], `GCT_REG_CNT), 0);
            check(rd, (i >= 2) ? 32'h7 : 32'h5);
        end
        apb(0, ra(1, `GCT_REG_CNT), 0); check(rd, 32'h5);
        $display("test gates done");
    endtask
    // Divider 8 gives a period of 9 base ticks: 18 periods in 1800 clocks.
    task automatic t_rate();
        int e0, l0, act;
        apb(1, ra(0, `GCT_REG_DIV), 32'h8);
        apb(1, ra(0, `GCT_REG_DUTY), 32'd50);
        for (int pol = 0; pol < 2; pol++) begin
            apb(1, ra(0, `GCT_REG_CTRL), (32'h1 << `GCT_CTRL_RATE) | (pol << `GCT_CTRL_POL));
            apb(1, `GCT_ADDR_START, 32'h1);
            repeat (200) @(posedge clk);
            e0 = gct_pins_model_i.edgeCnt;
            l0 = gct_pins_model_i.lowCnt;
            repeat (1800) @(posedge clk);
            act = gct_pins_model_i.lowCnt - l0;
            if (pol == 1) act = 1800 - act;
            check(32'(gct_pins_model_i.edgeCnt - e0 inside {[17:19]}), 32'h1);
            check(32'(act inside {[780:820]}), 32'h1);
        end
        apb(1, `GCT_ADDR_STOP, 32'h1);
        $display("test rate done");
    endtask
    task automatic t_sample();
        apb(1, `GCT_ADDR_LIST, 32'h1 | (32'h1 << `GCT_LIST_UPPER));
        waitValid(400);
        check({sampleUpper, sampleData}, 17'h0_0005);
        @(posedge clk) #1;
        check({sampleValid, sampleUpper, sampleData}, 18'h3_0000);
        apb(1, `GCT_ADDR_LIST, 32'h4);
        waitValid(400);
        check({sampleUpper, sampleData}, 17'h0_0007);
        @(posedge clk) #1;
        check(32'(sampleValid), 32'h0);
        apb(1, `GCT_ADDR_CONV, 32'hffff_ffff);
        apb(1, `GCT_ADDR_LIST, 32'h2 | (32'h1 << `GCT_LIST_EXTCONV));
        fork
            gct_pins_model_i.convPulse();
            waitValid(40);
        join
        check(32'(sampleData), 32'h5);
        $display("test sample done");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_none();
        t_gates();
        t_rate();
        t_sample();
        end_sim();
    end
endmodule
`default_nettype wire

//--- tb/gct_pins_model.sv
// Purpose: Far side of the channel pins: clock, gate and conversion sources.
// Assumes: Driven from bench tasks; clk is the bank clock.
// Notes:   Clock pins stand still between bursts.
`timescale 1ns/1ps
`default_nettype none
module gct_pins_model (
    // Clock
    input  wire logic       clk,
    // Pins toward the bank
    output logic      [4:0] ctClkPin,
    output logic      [4:0] ctGatePin,
    output logic            convClkPin,
    // Pulse outputs of the bank
    input  wire logic [4:0] ctOut
);
    int   edgeCnt = 0;
    int   lowCnt  = 0;
    logic outPrev = 1'b1;
    initial begin
        ctClkPin   = 5'h00;
        ctGatePin  = 5'h00;
        convClkPin = 1'b0;
    end
    // Pulse consumer on channel 0: rising edges and low cycles.
    always @(posedge clk) begin
        if (ctOut[0] === 1'b0) lowCnt <= lowCnt + 1;
        if (ctOut[0] === 1'b1 && outPrev === 1'b0) edgeCnt <= edgeCnt + 1;
        outPrev <= ctOut[0];
    end
    // A 24-cycle period keeps the pin under the fastest accepted rate.
    task automatic clkPulses(input int ch, input int n);
        repeat (n) begin
            @(posedge clk) ctClkPin[ch] <= 1'b1;
            repeat (12) @(posedge clk);
            ctClkPin[ch] <= 1'b0;
            repeat (11) @(posedge clk);
        end
        repeat (6) @(posedge clk);
    endtask
    task automatic setGate(input int ch, input logic v);
        @(posedge clk) ctGatePin[ch] <= v;
        repeat (6) @(posedge clk);
    endtask
    task automatic convPulse();
        @(posedge clk) convClkPin <= 1'b1;
        repeat (12) @(posedge clk);
        convClkPin <= 1'b0;
        repeat (11) @(posedge clk);
    endtask
endmodule
`default_nettype wire
